//--- hw/psc_pkg.sv
// Function
// - Power-down entry: CKE low, CS_n high; hold
// - Drive idle command the cycle after entry
// - No CKE drop during reads, writes, mode cmds
// - Entry allowed during activate/precharge/refresh
// - Bound power-down time for refresh needs
// - Exit: CKE high, CS_n high, hold
// - No command before exit latency passes
// - Two stable clocks before raising CKE
// - Read/mode read guard before CKE low
// - Write guard before CKE low
// - Write with auto precharge guard, one extra
// - Activate/precharge/refresh hold before CKE low
// - Mode write period before CKE low
// - Deep sleep entry encoding, then idle command
// - Deep sleep exit with stable clock, reinit
// - Clock stop in power-down after row timing
// - Clock stop with CKE high: CS_n high
// - Ready two clocks plus exit latency later
// - Idle encodings, CKE steady across cycles
`default_nettype none
package psc_pkg;
  // ****************************************
  // Widths and clock
  // ****************************************
  localparam int TMR_W = 8;
  localparam int CA_W = 10;
  localparam int TCK_PS = 40000;

  // ****************************************
  // Times in picoseconds
  // ****************************************
  localparam int DQSCK_MAX_PS = 5500;
  localparam int WR_PS = 15000;
  localparam int IHCKE_PS = 900;
  localparam int ISCKE_PS = 250;
  localparam int RCD_PS = 18000;
  localparam int RP_PS = 18000;
  localparam int REFI_PS = 3900000;

  // ****************************************
  // Counts in clock cycles
  // ****************************************
  localparam int READ_LAT = 3;
  localparam int WRITE_LAT = 1;
  localparam int BURST_LEN = 4;
  localparam int MODE_WR_CYC = 5;
  localparam int CKE_MIN_CYC = 3;
  localparam int XP_CYC = 2;
  localparam int STABLE_CLK_CYC = 2;

  // Round a time up to whole cycles, never below one
  function automatic int round_up(input int ps);
    int c;
    c = (ps + TCK_PS - 1) / TCK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_GUARD =
    READ_LAT + round_up(DQSCK_MAX_PS) + BURST_LEN / 2 + 1;
  localparam int WR_GUARD = WRITE_LAT + 1 + BURST_LEN / 2 + round_up(WR_PS);
  localparam int WRAP_GUARD = WR_GUARD + 1;
  localparam int IHCKE_CYC = round_up(IHCKE_PS);
  localparam int ISCKE_CYC = round_up(ISCKE_PS);
  localparam int RCD_CYC = round_up(RCD_PS);
  localparam int RP_CYC = round_up(RP_PS);
  localparam int PD_MAX_CYC = REFI_PS / TCK_PS;
  localparam int HOLD_CYC =
    (CKE_MIN_CYC > STABLE_CLK_CYC) ? CKE_MIN_CYC : STABLE_CLK_CYC;
  localparam int EXIT_CYC = (CKE_MIN_CYC > XP_CYC) ? CKE_MIN_CYC : XP_CYC;
  localparam int WAKE_DEEP_CYC = STABLE_CLK_CYC + ISCKE_CYC;
  localparam int WAKE_CS_CYC = STABLE_CLK_CYC + XP_CYC;

  // ****************************************
  // Pin encodings
  // ****************************************
  localparam logic [2:0] CA_DEEP = 3'h3;
  localparam logic [2:0] CA_IDLE = 3'h7;

  typedef enum logic [3:0] {
    ST_ACTIVE     = 4'h0,
    ST_PD_ENTER   = 4'h1,
    ST_PD_HOLD    = 4'h2,
    ST_PD         = 4'h3,
    ST_PD_CLKOFF  = 4'h4,
    ST_PD_WAKE    = 4'h5,
    ST_PD_EXIT    = 4'h6,
    ST_DEEP_ENTER  = 4'h7,
    ST_DEEP        = 4'h8,
    ST_DEEP_CLKOFF = 4'h9,
    ST_DEEP_WAKE   = 4'hA,
    ST_CS_STOP    = 4'hB,
    ST_CS_WAKE    = 4'hC
  } psc_state_type;

  typedef enum logic [2:0] {
    CMD_READ     = 3'h0,
    CMD_WRITE    = 3'h1,
    CMD_WRITE_AP = 3'h2,
    CMD_MODE_RD  = 3'h3,
    CMD_MODE_WR  = 3'h4,
    CMD_ACT      = 3'h5,
    CMD_PRE      = 3'h6,
    CMD_REF      = 3'h7
  } psc_cmd_type;
endpackage
`default_nettype wire

//--- hw/psc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Load request and busy flag of one hold-off timer
interface psc_tmr_if;
  logic                       load;
  logic [psc_pkg::TMR_W-1:0]  value;
  logic                       busy;
  modport timer (input load, input value, output busy);
  modport user (output load, output value, input busy);
endinterface
`default_nettype wire

//--- hw/psc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter; a load only ever lengthens the wait
module psc_timer (
  input wire logic   clk,
  input wire logic   reset,
  psc_tmr_if.timer   tif
);
  logic [psc_pkg::TMR_W-1:0] cnt_q;
  logic [psc_pkg::TMR_W-1:0] cnt_dec;
  logic [psc_pkg::TMR_W-1:0] cnt_d;

  // Count down, take the longer of remaining and loaded
  assign cnt_dec = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
  assign cnt_d = (tif.load && tif.value > cnt_dec) ? tif.value : cnt_dec;
  assign tif.busy = (cnt_q != '0);

  // Counter register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

//--- hw/psc_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module psc_power_ctrl #(
  parameter int PD_MAX_CYC = psc_pkg::PD_MAX_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       cmd_valid,
  input  wire psc_pkg::psc_cmd_type       cmd_kind,
  input  wire logic [psc_pkg::CA_W-1:0]   cmd_ca,
  input  wire logic                       pd_req,
  input  wire logic                       deep_req,
  input  wire logic                       stop_req,
  input  wire logic                       init_done,
  output logic                            cmd_ready_q,
  output logic                            mem_cke_q,
  output logic                            mem_cs_n_q,
  output logic [psc_pkg::CA_W-1:0]        mem_ca_q,
  output logic                            mem_clk_run_q,
  output logic                            in_pd_q,
  output logic                            active_pd_q,
  output logic                            in_deep_q,
  output logic                            reinit_q
);
  localparam int NTMR = 3;
  localparam int G = 0;
  localparam int R = 1;
  localparam int S = 2;
  localparam logic [psc_pkg::TMR_W-1:0] PD_MAX_W =
    psc_pkg::TMR_W'(PD_MAX_CYC);

  // ****************************************
  // Declarations
  // ****************************************
  psc_pkg::psc_state_type       state_q;
  psc_pkg::psc_state_type       state_d;
  logic                         cmd_take;
  logic                         guard_busy;
  logic                         row_busy;
  logic                         st_busy;
  logic                         st_load;
  logic [psc_pkg::TMR_W-1:0]    st_val;
  logic [psc_pkg::TMR_W-1:0]    guard_val;
  logic [psc_pkg::TMR_W-1:0]    row_val;
  logic [psc_pkg::TMR_W-1:0]    pd_cnt_q;
  logic                         pd_hit;
  logic                         ref_due_q;
  logic                         open_q;
  logic                         in_pd_d;
  logic                         in_deep_d;
  logic                         cke_d;
  logic                         cs_n_d;
  logic                         clk_run_d;
  logic [psc_pkg::CA_W-1:0]     ca_d;
  logic                         deep_exit;
  logic                         pd_exit_go;

  psc_tmr_if tmr [NTMR] ();

  // ****************************************
  // Hold-off timers: guard, row, state
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NTMR; gi++)
    begin : g_tmr
      psc_timer u_tmr (
        .clk   (core_clk),
        .reset (reset),
        .tif   (tmr[gi])
      );
    end
  endgenerate

  // Command accepted only when the link is idle and awake
  assign cmd_take = cmd_valid && cmd_ready_q &&
    (state_q == psc_pkg::ST_ACTIVE);

  // Guard before CKE may fall, per command kind
  assign guard_val =
    (cmd_kind == psc_pkg::CMD_READ) ?
      psc_pkg::TMR_W'(psc_pkg::RD_GUARD) :
    (cmd_kind == psc_pkg::CMD_MODE_RD) ?
      psc_pkg::TMR_W'(psc_pkg::RD_GUARD) :
    (cmd_kind == psc_pkg::CMD_WRITE) ?
      psc_pkg::TMR_W'(psc_pkg::WR_GUARD) :
    (cmd_kind == psc_pkg::CMD_WRITE_AP) ?
      psc_pkg::TMR_W'(psc_pkg::WRAP_GUARD) :
    (cmd_kind == psc_pkg::CMD_MODE_WR) ?
      psc_pkg::TMR_W'(psc_pkg::MODE_WR_CYC) :
      psc_pkg::TMR_W'(psc_pkg::IHCKE_CYC);

  // Row timing that must finish before a clock stop
  assign row_val = (cmd_kind == psc_pkg::CMD_ACT) ?
    psc_pkg::TMR_W'(psc_pkg::RCD_CYC) :
    psc_pkg::TMR_W'(psc_pkg::RP_CYC);

  // Timer connections
  assign tmr[G].load = cmd_take;
  assign tmr[G].value = guard_val;
  assign tmr[R].load = cmd_take && (cmd_kind == psc_pkg::CMD_ACT ||
    cmd_kind == psc_pkg::CMD_PRE);
  assign tmr[R].value = row_val;
  assign tmr[S].load = st_load;
  assign tmr[S].value = st_val;
  assign guard_busy = tmr[G].busy;
  assign row_busy = tmr[R].busy;
  assign st_busy = tmr[S].busy;

  // Refresh bound on time spent in power-down
  assign pd_hit = (pd_cnt_q >= PD_MAX_W);
  assign pd_exit_go = !pd_req || pd_hit;
  assign deep_exit = (state_q == psc_pkg::ST_DEEP_WAKE) && !st_busy;

  // ****************************************
  // State machine
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    st_load = 1'b0;
    st_val = '0;
    case (state_q)
      psc_pkg::ST_ACTIVE:
      begin
        // Entry waits out every command guard
        if (!cmd_take && !guard_busy)
        begin
          if (deep_req)
            state_d = psc_pkg::ST_DEEP_ENTER;
          else if (pd_req && !ref_due_q)
            state_d = psc_pkg::ST_PD_ENTER;
          else if (stop_req && !row_busy)
            state_d = psc_pkg::ST_CS_STOP;
        end
      end
      psc_pkg::ST_PD_ENTER:
      begin
        // Hold CKE low and keep the clock for three cycles
        state_d = psc_pkg::ST_PD_HOLD;
        st_load = 1'b1;
        st_val = psc_pkg::TMR_W'(psc_pkg::HOLD_CYC);
      end
      psc_pkg::ST_PD_HOLD:
      begin
        if (!st_busy)
          state_d = psc_pkg::ST_PD;
      end
      psc_pkg::ST_PD:
      begin
        if (pd_exit_go)
        begin
          state_d = psc_pkg::ST_PD_WAKE;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::STABLE_CLK_CYC);
        end
        else if (stop_req && !row_busy)
          state_d = psc_pkg::ST_PD_CLKOFF;
      end
      psc_pkg::ST_PD_CLKOFF:
      begin
        if (pd_exit_go || !stop_req)
        begin
          state_d = psc_pkg::ST_PD_WAKE;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::STABLE_CLK_CYC);
        end
      end
      psc_pkg::ST_PD_WAKE:
      begin
        // Clock runs stable before CKE rises
        if (!st_busy)
        begin
          state_d = psc_pkg::ST_PD_EXIT;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::EXIT_CYC);
        end
      end
      psc_pkg::ST_PD_EXIT:
      begin
        if (!st_busy)
          state_d = psc_pkg::ST_ACTIVE;
      end
      psc_pkg::ST_DEEP_ENTER:
      begin
        // Next cycle is an idle command; clock kept three cycles
        state_d = psc_pkg::ST_DEEP;
        st_load = 1'b1;
        st_val = psc_pkg::TMR_W'(psc_pkg::HOLD_CYC);
      end
      psc_pkg::ST_DEEP:
      begin
        if (!st_busy && !deep_req)
        begin
          state_d = psc_pkg::ST_DEEP_WAKE;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::WAKE_DEEP_CYC);
        end
        else if (!st_busy && stop_req)
          state_d = psc_pkg::ST_DEEP_CLKOFF;
      end
      psc_pkg::ST_DEEP_CLKOFF:
      begin
        if (!deep_req || !stop_req)
        begin
          state_d = psc_pkg::ST_DEEP_WAKE;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::WAKE_DEEP_CYC);
        end
      end
      psc_pkg::ST_DEEP_WAKE:
      begin
        if (!st_busy)
        begin
          state_d = psc_pkg::ST_PD_EXIT;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::EXIT_CYC);
        end
      end
      psc_pkg::ST_CS_STOP:
      begin
        if (!stop_req)
        begin
          state_d = psc_pkg::ST_CS_WAKE;
          st_load = 1'b1;
          st_val = psc_pkg::TMR_W'(psc_pkg::WAKE_CS_CYC);
        end
      end
      psc_pkg::ST_CS_WAKE:
      begin
        if (!st_busy)
          state_d = psc_pkg::ST_ACTIVE;
      end
      default:
        state_d = psc_pkg::ST_ACTIVE;
    endcase
  end

  // ****************************************
  // Pin decode from the next state
  // ****************************************
  // CKE high only while awake or leaving power-down
  assign cke_d = (state_d == psc_pkg::ST_ACTIVE) ||
    (state_d == psc_pkg::ST_PD_EXIT) ||
    (state_d == psc_pkg::ST_CS_STOP) ||
    (state_d == psc_pkg::ST_CS_WAKE);

  // CS_n low only for a command or deep sleep entry
  assign cs_n_d = !(cmd_take || state_d == psc_pkg::ST_DEEP_ENTER);

  // CA carries the command, deep sleep code or NO_OPERATION code
  assign ca_d = cmd_take ? cmd_ca :
    (state_d == psc_pkg::ST_DEEP_ENTER) ?
      {{(psc_pkg::CA_W-3){1'b1}}, psc_pkg::CA_DEEP} :
      {{(psc_pkg::CA_W-3){1'b1}}, psc_pkg::CA_IDLE};

  // Clock stopped only in the clock-off states and in ST_CS_STOP
  assign clk_run_d = !(state_d == psc_pkg::ST_PD_CLKOFF ||
    state_d == psc_pkg::ST_DEEP_CLKOFF ||
    state_d == psc_pkg::ST_CS_STOP);

  // Status decode
  assign in_pd_d = (state_d == psc_pkg::ST_PD_ENTER) ||
    (state_d == psc_pkg::ST_PD_HOLD) || (state_d == psc_pkg::ST_PD) ||
    (state_d == psc_pkg::ST_PD_CLKOFF) || (state_d == psc_pkg::ST_PD_WAKE);
  assign in_deep_d = (state_d == psc_pkg::ST_DEEP_ENTER) ||
    (state_d == psc_pkg::ST_DEEP) || (state_d == psc_pkg::ST_DEEP_CLKOFF) ||
    (state_d == psc_pkg::ST_DEEP_WAKE);

  // ****************************************
  // Registers
  // ****************************************
  // State and pins
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= psc_pkg::ST_ACTIVE;
      mem_cke_q <= 1'b1;
      mem_cs_n_q <= 1'b1;
      mem_ca_q <= '1;
      mem_clk_run_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      mem_cke_q <= cke_d;
      mem_cs_n_q <= cs_n_d;
      mem_ca_q <= ca_d;
      mem_clk_run_q <= clk_run_d;
    end
  end

  // Status outputs; ready waits out exit latency
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cmd_ready_q <= 1'b1;
      in_pd_q <= 1'b0;
      active_pd_q <= 1'b0;
      in_deep_q <= 1'b0;
    end
    else
    begin
      cmd_ready_q <= (state_d == psc_pkg::ST_ACTIVE);
      in_pd_q <= in_pd_d;
      active_pd_q <= in_pd_d && open_q;
      in_deep_q <= in_deep_d;
    end
  end

  // Open-row tracking; precharge closes all rows
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      open_q <= 1'b0;
    else if (cmd_take && cmd_kind == psc_pkg::CMD_ACT)
      open_q <= 1'b1;
    else if (cmd_take && cmd_kind == psc_pkg::CMD_PRE)
      open_q <= 1'b0;
    else if (deep_exit)
      open_q <= 1'b0;
  end

  // Power-down dwell counter
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      pd_cnt_q <= '0;
    else if (!in_pd_d)
      pd_cnt_q <= '0;
    else if (!pd_hit)
      pd_cnt_q <= pd_cnt_q + 1'b1;
  end

  // Refresh owed after a forced exit; set wins
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      ref_due_q <= 1'b0;
    else if (pd_hit && in_pd_q && !in_pd_d)
      ref_due_q <= 1'b1;
    else if (cmd_take && cmd_kind == psc_pkg::CMD_REF)
      ref_due_q <= 1'b0;
  end

  // Reinit needed after deep sleep; set wins
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      reinit_q <= 1'b0;
    else if (deep_exit)
      reinit_q <= 1'b1;
    else if (init_done)
      reinit_q <= 1'b0;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  pd_entry_nop_a: assert property (
    $fell(mem_cke_q) && mem_cs_n_q |=> !mem_cke_q && mem_cs_n_q)
    else $error("no idle command after power-down entry");

  cke_low_hold_a: assert property (
    $fell(mem_cke_q) |-> !mem_cke_q [*3])
    else $error("CKE low too short");

  cke_high_hold_a: assert property (
    $rose(mem_cke_q) |-> mem_cs_n_q ##0 mem_cke_q [*3])
    else $error("bad power-down exit");

  exit_latency_a: assert property (
    $rose(mem_cke_q) |-> !cmd_ready_q [*2])
    else $error("command allowed inside exit latency");

  stable_clock_a: assert property (
    $rose(mem_cke_q) |-> $past(mem_clk_run_q) && $past(mem_clk_run_q, 2))
    else $error("CKE rose without stable clock");

  read_guard_a: assert property (
    cmd_take && cmd_kind == psc_pkg::CMD_READ |=> mem_cke_q [*8])
    else $error("CKE fell inside read burst");

  wrap_guard_a: assert property (
    cmd_take && cmd_kind == psc_pkg::CMD_WRITE_AP |=> mem_cke_q [*7])
    else $error("CKE fell inside write recovery");

  deep_entry_a: assert property (
    $fell(mem_cke_q) && !mem_cs_n_q |->
      mem_ca_q[2:0] == psc_pkg::CA_DEEP ##1 mem_cs_n_q)
    else $error("bad deep sleep entry");

  pd_bound_a: assert property (
    state_q == psc_pkg::ST_PD && pd_hit |=> state_q == psc_pkg::ST_PD_WAKE)
    else $error("power-down dwell exceeded");

  clk_stop_cs_a: assert property (
    !mem_clk_run_q && mem_cke_q |-> mem_cs_n_q && !cmd_ready_q)
    else $error("clock stopped while selected");

  reinit_flag_a: assert property (
    $rose(reinit_q) |-> mem_cke_q && !in_deep_q)
    else $error("reinit raised outside deep exit");

  pd_cycle_c: cover property (
    $fell(mem_cke_q) && mem_cs_n_q ##[1:300] $rose(mem_cke_q));
  deep_cycle_c: cover property ($rose(in_deep_q) ##[1:300] $rose(reinit_q));
  stop_high_c: cover property (!mem_clk_run_q && mem_cke_q);
  active_pd_c: cover property ($rose(active_pd_q));
endmodule
`default_nettype wire

//--- tb/psc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Memory device seen from its pins
// ********
module psc_dev_model (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     mem_cke_q,
  input  wire logic                     mem_cs_n_q,
  input  wire logic [psc_pkg::CA_W-1:0] mem_ca_q,
  input  wire logic                     mem_clk_run_q,
  output logic [1:0]                    dev_mode,
  output var int                        err_count
);
  logic [1:0] mode_q;
  logic       cke_prev;
  logic       nop_due;
  int         low_cnt;
  int         high_cnt;
  int         run_cnt;

  // Pin decode; commands count only with enable high twice
  wire logic is_nop = mem_cs_n_q || mem_ca_q[2:0] == 3'h7;
  wire logic is_cmd = !is_nop && mem_cke_q && cke_prev;
  wire logic fall = cke_prev && !mem_cke_q;
  wire logic rise = !cke_prev && mem_cke_q;
  wire logic bad_run =
    (nop_due && !is_nop) ||
    (fall && high_cnt < psc_pkg::CKE_MIN_CYC) ||
    (fall && !mem_cs_n_q && mem_ca_q[2:0] != 3'h3) ||
    (rise && low_cnt < psc_pkg::CKE_MIN_CYC) ||
    (rise && run_cnt < psc_pkg::STABLE_CLK_CYC) ||
    (rise && mode_q == 2'h1 && !mem_cs_n_q) ||
    (is_cmd && high_cnt < psc_pkg::XP_CYC) ||
    (is_cmd && run_cnt < 2 + psc_pkg::XP_CYC);
  wire logic bad_stop = (mem_cke_q && !mem_cs_n_q) ||
    (!mem_cke_q && low_cnt < 2);

  // Deep sleep left on the enable level alone, no edge needed
  assign dev_mode = (mode_q == 2'h2 && mem_cke_q) ? 2'h0 : mode_q;

  // Sampling on edges where the memory clock runs
  always @(posedge core_clk or posedge reset)
    if (reset)
    begin
      mode_q <= 2'h0;
      cke_prev <= 1'b1;
      nop_due <= 1'b0;
      low_cnt <= 0;
      high_cnt <= 100;
      run_cnt <= 100;
      err_count <= 0;
    end
    else if (!mem_clk_run_q)
    begin
      run_cnt <= 0;
      err_count <= err_count + int'(bad_stop);
    end
    else
    begin
      run_cnt <= run_cnt + 1;
      cke_prev <= mem_cke_q;
      nop_due <= fall;
      low_cnt <= mem_cke_q ? 0 : low_cnt + 1;
      high_cnt <= mem_cke_q ? high_cnt + 1 : 0;
      err_count <= err_count + int'(bad_run);
      if (fall)
        mode_q <= mem_cs_n_q ? 2'h1 : 2'h2;
      else if (rise)
        mode_q <= 2'h0;
    end
endmodule
`default_nettype wire

//--- tb/test_psc_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Power state controller bench
// ********
module test_psc_power_ctrl;
  localparam int TCK = psc_pkg::TCK_PS;
  localparam int PD_MAX = 20;
  localparam int RD_G = psc_pkg::READ_LAT + psc_pkg::BURST_LEN / 2 + 1
    + (psc_pkg::DQSCK_MAX_PS + TCK - 1) / TCK;
  localparam int WR_G = psc_pkg::WRITE_LAT + 1 + psc_pkg::BURST_LEN / 2
    + (psc_pkg::WR_PS + TCK - 1) / TCK;
  localparam int IH_G = (psc_pkg::IHCKE_PS + TCK - 1) / TCK;

  logic                      core_clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      cmd_valid = 1'b0;
  psc_pkg::psc_cmd_type      cmd_kind = psc_pkg::CMD_READ;
  logic [psc_pkg::CA_W-1:0]  cmd_ca = 10'h000;
  logic                      pd_req = 1'b0;
  logic                      deep_req = 1'b0;
  logic                      stop_req = 1'b0;
  logic                      init_done = 1'b0;
  logic                      cmd_ready_q;
  logic                      mem_cke_q;
  logic                      mem_cs_n_q;
  logic [psc_pkg::CA_W-1:0]  mem_ca_q;
  logic                      mem_clk_run_q;
  logic                      in_pd_q;
  logic                      active_pd_q;
  logic                      in_deep_q;
  logic                      reinit_q;
  logic [1:0]                dev_mode;
  int                        err_count;
  int                        bad_count = 0;
  int                        tests_run = 0;

  // Clock, 40 ns period
  always #20 core_clk = ~core_clk;

  psc_power_ctrl #(.PD_MAX_CYC(PD_MAX)) psc_power_ctrl_i (
    .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_ca(cmd_ca), .pd_req(pd_req),
    .deep_req(deep_req), .stop_req(stop_req), .init_done(init_done),
    .cmd_ready_q(cmd_ready_q), .mem_cke_q(mem_cke_q),
    .mem_cs_n_q(mem_cs_n_q), .mem_ca_q(mem_ca_q),
    .mem_clk_run_q(mem_clk_run_q), .in_pd_q(in_pd_q),
    .active_pd_q(active_pd_q), .in_deep_q(in_deep_q), .reinit_q(reinit_q));

  psc_dev_model psc_dev_model_i (
    .core_clk(core_clk), .reset(reset), .mem_cke_q(mem_cke_q),
    .mem_cs_n_q(mem_cs_n_q), .mem_ca_q(mem_ca_q),
    .mem_clk_run_q(mem_clk_run_q), .dev_mode(dev_mode),
    .err_count(err_count));

  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait on one output, counting falling edges
  function automatic logic pin(input int s);
    case (s)
      0: return mem_cke_q;
      1: return cmd_ready_q;
      default: return mem_clk_run_q;
    endcase
  endfunction

  task automatic wait_pin(input int s, input logic lvl, output int n);
    n = 0;
    while (pin(s) !== lvl && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    check(n < 200, 1'b1);
  endtask

  // One command, seen on the pins the next cycle
  task automatic issue(input psc_pkg::psc_cmd_type k);
    int n;
    wait_pin(1, 1'b1, n);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_ca = {7'h2B, k};
    @(negedge core_clk);
    cmd_valid = 1'b0;
    check({mem_cs_n_q, mem_ca_q}, {1'b0, 7'h2B, k});
  endtask

  // Command, guarded power-down entry, optional clock stop, exit
  task automatic pd_round(input psc_pkg::psc_cmd_type k, input int g,
                          input logic act, input logic stop);
    int n;
    pd_req = 1'b1;
    issue(k);
    wait_pin(0, 1'b0, n);
    check(n >= g && n <= g + 3, 1'b1);
    check({mem_cs_n_q, in_pd_q, active_pd_q, cmd_ready_q},
          {2'h3, act, 1'b0});
    @(negedge core_clk);
    check(mem_cs_n_q, 1'b1);
    if (stop)
    begin
      stop_req = 1'b1;
      wait_pin(2, 1'b0, n);
      check(mem_cke_q, 1'b0);
      repeat (3) @(negedge core_clk);
    end
    pd_req = 1'b0;
    stop_req = 1'b0;
    wait_pin(0, 1'b1, n);
    check({mem_cs_n_q, in_pd_q, mem_clk_run_q}, {3'h5});
    wait_pin(1, 1'b1, n);
    check(n >= psc_pkg::XP_CYC, 1'b1);
  endtask

  // Dwell limit, then re-entry only after a refresh
  task automatic dwell();
    int n;
    pd_req = 1'b1;
    wait_pin(0, 1'b0, n);
    wait_pin(0, 1'b1, n);
    check(n >= PD_MAX && n <= PD_MAX + 4, 1'b1);
    repeat (12) @(negedge core_clk);
    check(mem_cke_q, 1'b1);
    issue(psc_pkg::CMD_REF);
    wait_pin(0, 1'b0, n);
    check(in_pd_q, 1'b1);
    pd_req = 1'b0;
    wait_pin(1, 1'b1, n);
  endtask

  // Deep sleep entry, exit and reinitialisation flag
  task automatic deep();
    int n;
    deep_req = 1'b1;
    wait_pin(0, 1'b0, n);
    check({mem_cs_n_q, mem_ca_q[2:0], in_deep_q}, 5'h07);
    @(negedge core_clk);
    check({mem_cs_n_q, dev_mode}, 3'h6);
    repeat (4) @(negedge core_clk);
    deep_req = 1'b0;
    wait_pin(0, 1'b1, n);
    check({reinit_q, in_deep_q, dev_mode}, 4'h8);
    issue(psc_pkg::CMD_MODE_WR);
    init_done = 1'b1;
    @(negedge core_clk);
    init_done = 1'b0;
    check(reinit_q, 1'b0);
  endtask

  // Clock stop with enable high, held off by a write
  task automatic stop_awake();
    int n;
    issue(psc_pkg::CMD_WRITE);
    stop_req = 1'b1;
    wait_pin(2, 1'b0, n);
    check(n >= WR_G, 1'b1);
    check({mem_cke_q, mem_cs_n_q, cmd_ready_q}, 3'h6);
    repeat (5) @(negedge core_clk);
    stop_req = 1'b0;
    wait_pin(2, 1'b1, n);
    wait_pin(1, 1'b1, n);
    check(n + 1 >= 2 + psc_pkg::XP_CYC, 1'b1);
    issue(psc_pkg::CMD_READ);
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(negedge core_clk);
    check({mem_cke_q, mem_cs_n_q, mem_ca_q, mem_clk_run_q, cmd_ready_q,
           in_pd_q, active_pd_q, in_deep_q, reinit_q}, 18'h3FFF0);
    reset = 1'b0;
    pd_round(psc_pkg::CMD_PRE, IH_G, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_READ, RD_G, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_WRITE, WR_G, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_WRITE_AP, WR_G + 1, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_MODE_RD, RD_G, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_MODE_WR, psc_pkg::MODE_WR_CYC, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_REF, IH_G, 1'b0, 1'b0);
    pd_round(psc_pkg::CMD_ACT, IH_G, 1'b1, 1'b1);
    pd_round(psc_pkg::CMD_PRE, IH_G, 1'b0, 1'b0);
    dwell();
    deep();
    stop_awake();
    check(err_count, 0);
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
